// File: hw/fps_defs.vh
// Offsets, field positions, reset values and encodings of the protection supervisor.
`ifndef FPS_DEFS_VH
`define FPS_DEFS_VH
`define FPS_ADDR_W 5
`define FPS_OFF_CTRL 5'h00
`define FPS_OFF_STATUS 5'h04
`define FPS_OFF_IRQ_STAT 5'h08
`define FPS_OFF_IRQ_MASK 5'h0C
`define FPS_OFF_RST_DLY 5'h10
`define FPS_CTRL_EN_BIT 0
`define FPS_CTRL_RST 32'h0000_0001
`define FPS_MASK_RST 8'h00
`define FPS_DLY_W 24
`define FPS_DLY_RST 24'h00_9C40
`define FPS_EV_W 8
`define FPS_EV_LINE_OV 0
`define FPS_EV_BROWN 1
`define FPS_EV_OT_INT 2
`define FPS_EV_OPP 3
`define FPS_EV_OV_EXT 4
`define FPS_EV_OT_EXT 5
`define FPS_EV_LOCK 6
`define FPS_EV_PEAK 7
`define FPS_STATUS_IN_LSB 8
`define FPS_N_IN 12
`define FPS_RESP_OKAY 2'b00
`define FPS_RESP_SLVERR 2'b10
`endif

// File: hw/fps_supervisor.v
// Protection supervisor of a fixed-frequency flyback controller with AXI4-Lite registers.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`include "fps_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module fps_supervisor #(
    parameter LATCH_OPP = 0
) (
    // Clock and supply reset.
    input wire clk,
    input wire reset_n,
    // Comparator results from the sensing network.
    input wire line_over,
    input wire line_low,
    input wire line_start,
    input wire die_hot,
    input wire guard_high,
    input wire guard_low,
    input wire opp_level,
    input wire peak_level,
    input wire timer_trip,
    input wire supply_start,
    input wire supply_lockout,
    input wire supply_reset,
    // Power stage controls and the interrupt line.
    output reg gate_en_q,
    output reg cycle_cut_q,
    output reg timer_charge_q,
    output reg timer_discharge_q,
    output reg power_down_q,
    output reg clamp_latch_q,
    output reg clamp_lockout_q,
    output reg irq_q,
    // AXI4-Lite write address.
    input wire s_awvalid,
    output reg s_awready,
    input wire [31:0] s_awaddr,
    // AXI4-Lite write data.
    input wire s_wvalid,
    output reg s_wready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    // AXI4-Lite write response.
    output reg s_bvalid,
    input wire s_bready,
    output reg [1:0] s_bresp,
    // AXI4-Lite read address.
    input wire s_arvalid,
    output reg s_arready,
    input wire [31:0] s_araddr,
    // AXI4-Lite read data.
    output reg s_rvalid,
    input wire s_rready,
    output reg [31:0] s_rdata,
    output reg [1:0] s_rresp
);

    localparam [3:0] ST_OFF = 4'h1;
    localparam [3:0] ST_RUN = 4'h2;
    localparam [3:0] ST_RST = 4'h4;
    localparam [3:0] ST_LAT = 4'h8;

    wire [`FPS_N_IN-1:0] raw_in;
    reg [`FPS_N_IN-1:0] sync1_q;
    reg [`FPS_N_IN-1:0] sync2_q;
    wire l_over, l_low, l_start, d_hot, g_high, g_low;
    wire o_lvl, p_lvl, t_trip, s_start, s_lock, s_reset;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [`FPS_DLY_W-1:0] dly_cnt_q;
    reg [`FPS_DLY_W-1:0] dly_cnt_d;
    reg [`FPS_EV_W-1:0] ev;
    reg peak_q;
    reg [31:0] ctrl_q;
    reg [`FPS_EV_W-1:0] mask_q;
    reg [`FPS_EV_W-1:0] stat_q;
    reg [`FPS_DLY_W-1:0] dly_q;
    reg aw_got_q;
    reg w_got_q;
    reg [`FPS_ADDR_W-1:0] waddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire [31:0] wmask;
    wire do_wr;
    wire wr_ctrl, wr_stat, wr_mask, wr_dly;
    wire [`FPS_ADDR_W-1:0] raddr;
    wire latch_fault;
    wire restart_fault;
    wire opp_trip;
    wire start_ok;
    wire run_d;
    wire off_d;
    wire lat_d;
    wire wr_hit;

    assign raw_in = {supply_reset, supply_lockout, supply_start, timer_trip,
                     peak_level, opp_level, guard_low, guard_high,
                     die_hot, line_start, line_low, line_over};

    // Every comparator output is asynchronous to clk.
    // Two flops cost two cycles of reaction but keep metastability out of the state machine.
    genvar gi;
    generate
        for (gi = 0; gi < `FPS_N_IN; gi = gi + 1) begin : g_sync
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign l_over = sync2_q[0];
    assign l_low = sync2_q[1];
    assign l_start = sync2_q[2];
    assign d_hot = sync2_q[3];
    assign g_high = sync2_q[4];
    assign g_low = sync2_q[5];
    assign o_lvl = sync2_q[6];
    assign p_lvl = sync2_q[7];
    assign t_trip = sync2_q[8];
    assign s_start = sync2_q[9];
    assign s_lock = sync2_q[10];
    assign s_reset = sync2_q[11];

    // The timer node is only trusted while this block is charging it.
    assign opp_trip = timer_charge_q & t_trip;
    // A latching variant turns the overpower trip into a latch.
    assign latch_fault = d_hot | g_high | g_low | (opp_trip & (LATCH_OPP != 0));
    assign restart_fault = l_over | l_low | (opp_trip & (LATCH_OPP == 0));
    // Starting also needs the line above its start level.
    // A supply still in lockout or below its reset level must not start either.
    assign start_ok = s_start & l_start & ~l_over & ~l_low & ~d_hot & ~g_high & ~g_low
                      & ~s_lock & ~s_reset & ctrl_q[`FPS_CTRL_EN_BIT];

    // Output flops follow the next state so they change on the same edge as the state.
    assign run_d = (state_d == ST_RUN);
    assign off_d = (state_d == ST_OFF);
    assign lat_d = (state_d == ST_LAT);

    always @* begin
        state_d = state_q;
        dly_cnt_d = dly_cnt_q;
        ev = {`FPS_EV_W{1'b0}};
        case (state_q)
            ST_OFF: begin
                // Lockout and idle both wait here for the supply start level.
                if (start_ok) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                // Only the rising edge of the limit counts, so a long limit sets the flag once.
                ev[`FPS_EV_PEAK] = p_lvl & ~peak_q;
                if (latch_fault) begin
                    state_d = ST_LAT;
                    ev[`FPS_EV_OT_INT] = d_hot;
                    ev[`FPS_EV_OV_EXT] = g_high;
                    ev[`FPS_EV_OT_EXT] = g_low;
                    ev[`FPS_EV_OPP] = opp_trip;
                end else if (s_lock) begin
                    // No restart delay and no timer charge on this path.
                    state_d = ST_OFF;
                    ev[`FPS_EV_LOCK] = 1'b1;
                end else if (restart_fault) begin
                    state_d = ST_RST;
                    // The delay is loaded on entry, so a new value applies from the next restart.
                    dly_cnt_d = dly_q;
                    ev[`FPS_EV_LINE_OV] = l_over;
                    ev[`FPS_EV_BROWN] = l_low;
                    ev[`FPS_EV_OPP] = opp_trip;
                end
                // Peak limiting alone never leaves this state.
            end
            ST_RST: begin
                if (d_hot | g_high | g_low) begin
                    state_d = ST_LAT;
                    ev[`FPS_EV_OT_INT] = d_hot;
                    ev[`FPS_EV_OV_EXT] = g_high;
                    ev[`FPS_EV_OT_EXT] = g_low;
                end else if (dly_cnt_q == {`FPS_DLY_W{1'b0}}) begin
                    state_d = ST_OFF;
                end else begin
                    dly_cnt_d = dly_cnt_q - 1'b1;
                end
            end
            ST_LAT: begin
                // Only a supply collapse below the reset level frees the latch.
                if (s_reset) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_OFF;
            dly_cnt_q <= {`FPS_DLY_W{1'b0}};
            peak_q <= 1'b0;
            gate_en_q <= 1'b0;
            cycle_cut_q <= 1'b0;
            timer_charge_q <= 1'b0;
            timer_discharge_q <= 1'b1;
            power_down_q <= 1'b1;
            clamp_latch_q <= 1'b0;
            clamp_lockout_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dly_cnt_q <= dly_cnt_d;
            peak_q <= p_lvl;
            gate_en_q <= run_d;
            cycle_cut_q <= run_d & p_lvl;
            timer_charge_q <= run_d & o_lvl;
            // Discharge is the exact inverse of charge, so the node is never pushed both ways.
            // Discharge whenever the charge stops, also after a lockout.
            timer_discharge_q <= ~(run_d & o_lvl);
            power_down_q <= off_d | lat_d;
            clamp_latch_q <= lat_d;
            clamp_lockout_q <= off_d;
        end
    end

    // Write channel: address and data may arrive in either order.
    // Readies stay low while a response waits, so a second write cannot overtake it.
    assign do_wr = aw_got_q & w_got_q & ~s_bvalid;
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wr_ctrl = do_wr & (waddr_q == `FPS_OFF_CTRL);
    assign wr_stat = do_wr & (waddr_q == `FPS_OFF_IRQ_STAT);
    assign wr_mask = do_wr & (waddr_q == `FPS_OFF_IRQ_MASK);
    assign wr_dly = do_wr & (waddr_q == `FPS_OFF_RST_DLY);
    assign wr_hit = wr_ctrl | wr_stat | wr_mask | wr_dly
                    | (do_wr & (waddr_q == `FPS_OFF_STATUS));

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= `FPS_RESP_OKAY;
            waddr_q <= {`FPS_ADDR_W{1'b0}};
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_awvalid & s_awready) begin
                aw_got_q <= 1'b1;
                waddr_q <= s_awaddr[`FPS_ADDR_W-1:0];
            end
            if (s_wvalid & s_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            s_awready <= ~aw_got_q & ~(s_awvalid & s_awready) & ~s_bvalid;
            s_wready <= ~w_got_q & ~(s_wvalid & s_wready) & ~s_bvalid;
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_hit ? `FPS_RESP_OKAY : `FPS_RESP_SLVERR;
            end else if (s_bvalid & s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Registers, sticky flags and the interrupt line.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `FPS_CTRL_RST;
            mask_q <= `FPS_MASK_RST;
            stat_q <= {`FPS_EV_W{1'b0}};
            dly_q <= `FPS_DLY_RST;
            irq_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_mask) begin
                mask_q <= (mask_q & ~wmask[`FPS_EV_W-1:0])
                          | (wdata_q[`FPS_EV_W-1:0] & wmask[`FPS_EV_W-1:0]);
            end
            if (wr_dly) begin
                dly_q <= (dly_q & ~wmask[`FPS_DLY_W-1:0])
                         | (wdata_q[`FPS_DLY_W-1:0] & wmask[`FPS_DLY_W-1:0]);
            end
            // A new event in the clearing cycle survives the clear.
            if (wr_stat) begin
                stat_q <= (stat_q & ~(wdata_q[`FPS_EV_W-1:0] & wmask[`FPS_EV_W-1:0])) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
            // The line follows the flags one cycle late and stays high until they are cleared or masked.
            irq_q <= |(stat_q & mask_q);
        end
    end

    // Read channel: one outstanding read, data held until taken.
    // Address bits above the decoded window are ignored, so the map repeats every 32 bytes.
    assign raddr = s_araddr[`FPS_ADDR_W-1:0];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= `FPS_RESP_OKAY;
        end else begin
            if (s_rvalid) begin
                if (s_rready) begin
                    s_rvalid <= 1'b0;
                    s_arready <= 1'b1;
                end
            end else if (s_arready & s_arvalid) begin
                s_rvalid <= 1'b1;
                s_arready <= 1'b0;
                s_rresp <= `FPS_RESP_OKAY;
                case (raddr)
                    `FPS_OFF_CTRL: begin
                        s_rdata <= ctrl_q;
                    end
                    `FPS_OFF_STATUS: begin
                        s_rdata <= {12'h000, sync2_q, 4'h0, state_q};
                    end
                    `FPS_OFF_IRQ_STAT: begin
                        s_rdata <= {24'h00_0000, stat_q};
                    end
                    `FPS_OFF_IRQ_MASK: begin
                        s_rdata <= {24'h00_0000, mask_q};
                    end
                    `FPS_OFF_RST_DLY: begin
                        s_rdata <= {8'h00, dly_q};
                    end
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= `FPS_RESP_SLVERR;
                    end
                endcase
            end else begin
                s_arready <= 1'b1;
            end
        end
    end

endmodule // fps_supervisor

`default_nettype wire

// File: verif/fps_supervisor_chk.sv
// Concurrent checks on the protection supervisor ports.
`timescale 1ns/100ps
`default_nettype none
module fps_supervisor_chk (
    // Clock and supply reset.
    input wire clk,
    input wire reset_n,
    // Comparator results.
    input wire line_over,
    input wire line_low,
    input wire line_start,
    input wire die_hot,
    input wire guard_high,
    input wire guard_low,
    input wire opp_level,
    input wire peak_level,
    input wire supply_start,
    input wire supply_lockout,
    input wire supply_reset,
    // Stage controls.
    input wire gate_en_q,
    input wire cycle_cut_q,
    input wire timer_charge_q,
    input wire power_down_q,
    input wire clamp_latch_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Faults get five samples: two sync flops and the state flop, plus slack.
    property p_line; (line_over || line_low) [*5] |-> !gate_en_q; endproperty
    a_line: assert property (p_line) else $error("switching under line fault");
    property p_latf; (die_hot || guard_high || guard_low) [*5] |-> !gate_en_q; endproperty
    a_latf: assert property (p_latf) else $error("switching under latch fault");
    property p_lat; clamp_latch_q |-> power_down_q && !gate_en_q; endproperty
    a_lat: assert property (p_lat) else $error("latched but not powered down");
    property p_unlat; $fell(clamp_latch_q) |-> $past(supply_reset, 3); endproperty
    a_unlat: assert property (p_unlat) else $error("latch left without reset");
    property p_lock; supply_lockout [*5] |-> !gate_en_q && !timer_charge_q; endproperty
    a_lock: assert property (p_lock) else $error("switching in lockout");
    property p_chg; (opp_level && gate_en_q) [*5] |-> timer_charge_q; endproperty
    a_chg: assert property (p_chg) else $error("timer not charged");
    property p_dis; !opp_level [*4] |-> !timer_charge_q; endproperty
    a_dis: assert property (p_dis) else $error("timer charged without overpower");
    property p_cut; cycle_cut_q |-> $past(peak_level, 3); endproperty
    a_cut: assert property (p_cut) else $error("cycle cut without peak");
    property p_go; $rose(gate_en_q) |-> $past(line_start, 3) && $past(supply_start, 3); endproperty
    a_go: assert property (p_go) else $error("start below start level");
    c_lat: cover property ($rose(clamp_latch_q));
    c_cut: cover property ($rose(cycle_cut_q) ##1 gate_en_q);
    c_chg: cover property ($rose(timer_charge_q));
endmodule // fps_supervisor_chk
bind fps_supervisor fps_supervisor_chk u_fps_supervisor_chk (.clk(clk), .reset_n(reset_n),
    .line_over(line_over), .line_low(line_low), .line_start(line_start), .die_hot(die_hot),
    .guard_high(guard_high), .guard_low(guard_low), .opp_level(opp_level),
    .peak_level(peak_level), .supply_start(supply_start), .supply_lockout(supply_lockout),
    .supply_reset(supply_reset), .gate_en_q(gate_en_q), .cycle_cut_q(cycle_cut_q),
    .timer_charge_q(timer_charge_q), .power_down_q(power_down_q),
    .clamp_latch_q(clamp_latch_q));
`default_nettype wire

// File: verif/fps_stage.sv
// Behavioural power stage: overpower timer capacitor and supply discharge.
`timescale 1ns/100ps
`default_nettype none
module fps_stage #(
    parameter TRIP = 8,
    parameter DIS = 6
) (
    // Clock.
    input wire clk,
    // Controls from the supervisor.
    input wire timer_charge_q,
    input wire timer_discharge_q,
    input wire clamp_latch_q,
    // Mains pulled by the bench.
    input wire unplug,
    // Comparator results.
    output logic timer_trip,
    output logic supply_reset
);
    integer cap_q = 0;
    integer vcc_q = 0;
    // Counts stand in for capacitor voltages; no droop is modelled.
    always @(posedge clk) begin
        if (timer_discharge_q)
            cap_q <= 0;
        else if (timer_charge_q && cap_q < TRIP)
            cap_q <= cap_q + 1;
        vcc_q <= (clamp_latch_q && unplug) ? vcc_q + 1 : 0;
    end
    assign timer_trip = (cap_q >= TRIP);
    assign supply_reset = (vcc_q >= DIS);
endmodule // fps_stage
`default_nettype wire

// File: verif/fps_supervisor_tb.sv
// Self-checking bench of the protection supervisor.
`timescale 1ns/100ps
`default_nettype none
`include "fps_defs.vh"
module fps_supervisor_tb;
    logic clk = 0, reset_n = 0, unplug = 0;
    logic [11:0] cmp = 0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic [31:0] s_awaddr = 0, s_wdata = 0, s_araddr = 0;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, timer_trip, supply_reset;
    wire [1:0] s_bresp, s_rresp;
    wire [31:0] s_rdata;
    wire gate_en_q, cycle_cut_q, timer_charge_q, timer_discharge_q;
    wire power_down_q, clamp_latch_q, clamp_lockout_q, irq_q;
    wire lat_charge, lat_discharge, lat_clamp, lat_trip, lat_reset;
    integer n_fail = 0, samples_checked = 0, cyc = 0, i, k;
    always #12.5 clk = ~clk;
    fps_supervisor u_fps_supervisor (.clk(clk), .reset_n(reset_n),
        .line_over(cmp[0]), .line_low(cmp[1]), .line_start(cmp[2]), .die_hot(cmp[3]),
        .guard_high(cmp[4]), .guard_low(cmp[5]), .opp_level(cmp[6]), .peak_level(cmp[7]),
        .timer_trip(timer_trip), .supply_start(cmp[9]), .supply_lockout(cmp[10]),
        .supply_reset(supply_reset), .gate_en_q(gate_en_q), .cycle_cut_q(cycle_cut_q),
        .timer_charge_q(timer_charge_q), .timer_discharge_q(timer_discharge_q),
        .power_down_q(power_down_q), .clamp_latch_q(clamp_latch_q),
        .clamp_lockout_q(clamp_lockout_q), .irq_q(irq_q),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(4'hF),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp));
    fps_stage u_fps_stage (.clk(clk), .timer_charge_q(timer_charge_q),
        .timer_discharge_q(timer_discharge_q), .clamp_latch_q(clamp_latch_q),
        .unplug(unplug), .timer_trip(timer_trip), .supply_reset(supply_reset));
    // The latching overpower build shares every input but timer_trip and supply_reset, which come from its own stage; only its clamp is compared.
    fps_supervisor #(.LATCH_OPP(1)) u_fps_supervisor_lat (.clk(clk), .reset_n(reset_n),
        .line_over(cmp[0]), .line_low(cmp[1]), .line_start(cmp[2]), .die_hot(cmp[3]),
        .guard_high(cmp[4]), .guard_low(cmp[5]), .opp_level(cmp[6]), .peak_level(cmp[7]),
        .timer_trip(lat_trip), .supply_start(cmp[9]), .supply_lockout(cmp[10]),
        .supply_reset(lat_reset), .gate_en_q(), .cycle_cut_q(),
        .timer_charge_q(lat_charge), .timer_discharge_q(lat_discharge),
        .power_down_q(), .clamp_latch_q(lat_clamp), .clamp_lockout_q(), .irq_q(),
        .s_awvalid(s_awvalid), .s_awready(), .s_awaddr(s_awaddr),
        .s_wvalid(s_wvalid), .s_wready(), .s_wdata(s_wdata), .s_wstrb(4'hF),
        .s_bvalid(), .s_bready(s_bready), .s_bresp(),
        .s_arvalid(s_arvalid), .s_arready(), .s_araddr(s_araddr),
        .s_rvalid(), .s_rready(s_rready), .s_rdata(), .s_rresp());
    fps_stage u_fps_stage_lat (.clk(clk), .timer_charge_q(lat_charge),
        .timer_discharge_q(lat_discharge), .clamp_latch_q(lat_clamp),
        .unplug(unplug), .timer_trip(lat_trip), .supply_reset(lat_reset));
    task chk(input [31:0] g, input [31:0] e);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input [31:0] a, input [31:0] d, input [1:0] er);
        @(posedge clk);
        {s_awvalid, s_wvalid, s_bready} <= 3'h7;
        s_awaddr <= a;
        s_wdata <= d;
        do begin
            @(posedge clk);
            if (s_awready && s_awvalid) s_awvalid <= 0;
            if (s_wready && s_wvalid) s_wvalid <= 0;
            if (s_bvalid && s_bready) begin
                s_bready <= 0;
                chk(s_bresp, er);
            end
        end while (s_awvalid || s_wvalid || s_bready);
    endtask
    task rd(input [31:0] a, input [31:0] e, input [1:0] er);
        @(posedge clk);
        {s_arvalid, s_rready} <= 2'h3;
        s_araddr <= a;
        do begin
            @(posedge clk);
            if (s_arready && s_arvalid) s_arvalid <= 0;
            if (s_rvalid && s_rready) begin
                s_rready <= 0;
                chk(s_rdata, e);
                chk(s_rresp, er);
            end
        end while (s_rready);
    endtask
    task put(input integer b, input v, input integer n);
        @(posedge clk);
        cmp[b] <= v;
        repeat (n) @(posedge clk);
    endtask
    task till_up;
        for (k = 0; k < 60 && gate_en_q !== 1'b1; k = k + 1) @(posedge clk);
        chk(gate_en_q, 1);
    endtask
    task test_done;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail = n_fail + 1;
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        chk({gate_en_q, power_down_q, clamp_latch_q, timer_discharge_q}, 4'h5);
        reset_n <= 1;
        rd(`FPS_OFF_CTRL, `FPS_CTRL_RST, 2'h0);
        rd(`FPS_OFF_RST_DLY, `FPS_DLY_RST, 2'h0);
        rd(`FPS_OFF_IRQ_MASK, 32'h0, 2'h0);
        rd(32'h14, 32'h0, `FPS_RESP_SLVERR);
        wr(32'h14, 32'hFFFF_FFFF, `FPS_RESP_SLVERR);
        wr(`FPS_OFF_STATUS, 32'hFFFF_FFFF, 2'h0);
        // A short delay keeps each restart within a few dozen cycles.
        wr(`FPS_OFF_RST_DLY, 32'h8, 2'h0);
        wr(`FPS_OFF_IRQ_MASK, 32'hFF, 2'h0);
        put(9, 1, 6);
        chk(gate_en_q, 0);
        put(2, 1, 0);
        till_up;
        rd(`FPS_OFF_STATUS, 32'h0002_0402, 2'h0);
        put(7, 1, 5);
        chk({cycle_cut_q, gate_en_q, irq_q}, 3'h7);
        put(7, 0, 0);
        rd(`FPS_OFF_IRQ_STAT, 32'h80, 2'h0);
        wr(`FPS_OFF_IRQ_STAT, 32'h80, 2'h0);
        rd(`FPS_OFF_IRQ_STAT, 32'h0, 2'h0);
        chk(irq_q, 0);
        wr(`FPS_OFF_IRQ_MASK, 32'h0, 2'h0);
        for (i = 0; i < 2; i = i + 1) begin
            put(i, 1, 5);
            chk({gate_en_q, power_down_q}, 2'h0);
            put(i, 0, 3);
            chk(gate_en_q, 0);
            till_up;
        end
        for (i = 3; i < 6; i = i + 1) begin
            put(i, 1, 5);
            chk({gate_en_q, power_down_q, clamp_latch_q}, 3'h3);
            put(i, 0, 8);
            chk(clamp_latch_q, 1);
            unplug <= 1;
            repeat (14) @(posedge clk);
            chk(clamp_latch_q, 0);
            unplug <= 0;
            till_up;
        end
        chk(irq_q, 0);
        rd(`FPS_OFF_IRQ_STAT, 32'h37, 2'h0);
        wr(`FPS_OFF_IRQ_MASK, 32'hFF, 2'h0);
        repeat (2) @(posedge clk);
        chk(irq_q, 1);
        wr(`FPS_OFF_IRQ_STAT, 32'h37, 2'h0);
        rd(`FPS_OFF_IRQ_STAT, 32'h0, 2'h0);
        chk(irq_q, 0);
        put(6, 1, 5);
        chk({timer_charge_q, timer_discharge_q, gate_en_q}, 3'h5);
        repeat (14) @(posedge clk);
        chk({gate_en_q, clamp_latch_q, lat_clamp}, 3'h1);
        put(6, 0, 0);
        till_up;
        put(6, 1, 5);
        chk(timer_charge_q, 1);
        put(6, 0, 4);
        chk({timer_charge_q, timer_discharge_q, gate_en_q}, 3'h3);
        @(posedge clk);
        cmp[10] <= 1;
        cmp[9] <= 0;
        repeat (5) @(posedge clk);
        chk({gate_en_q, power_down_q, clamp_lockout_q, timer_charge_q}, 4'h6);
        put(10, 0, 8);
        chk(gate_en_q, 0);
        put(9, 1, 6);
        chk(gate_en_q, 1);
        chk(lat_clamp, 1);
        rd(`FPS_OFF_IRQ_STAT, 32'h48, 2'h0);
        test_done;
    end
endmodule // fps_supervisor_tb
`default_nettype wire
